// >>> include/rcs_pkg.sv
// Package for the reset-cause status block: register offsets, field positions,
// reset values, timing counts and the shared carrier types.
// Assumes a 125 MHz system clock and an APB register bus with 32-bit data.
package rcs_pkg;

  // Register byte addresses on APB (index times four for the two indexed registers, as 03h is not word aligned).
  localparam logic [7:0]  IDX_CORE_STATUS   = 8'h03;
  localparam logic [7:0]  IDX_POWER_CONTROL = 8'h8e;
  localparam logic [11:0] ADDR_CORE_STATUS   = 12'h00c;
  localparam logic [11:0] ADDR_POWER_CONTROL = 12'h238;
  localparam logic [11:0] ADDR_CONFIG        = 12'h400;
  localparam logic [11:0] ADDR_IRQ_STATUS    = 12'h404;
  localparam logic [11:0] ADDR_IRQ_ENABLE    = 12'h408;
  localparam logic [11:0] ADDR_IRQ_CLEAR     = 12'h40c;
  localparam logic [11:0] ADDR_PC_LOW        = 12'h410;
  localparam logic [11:0] ADDR_PORT_LATCH    = 12'h414;
  localparam logic [11:0] ADDR_SERIAL_ADDR   = 12'h418;
  localparam logic [11:0] ADDR_SERIAL_CTRL   = 12'h41c;
  localparam logic [11:0] ADDR_WAKE_FLAGS    = 12'h420;

  // Power control fields.
  localparam int PC_BROWNOUT_BIT  = 0;
  localparam int PC_POWERON_BIT   = 1;
  localparam int PC_SOFT_BOR_BIT  = 4;
  localparam int PC_ULP_WAKE_BIT  = 5;
  localparam logic [7:0] PC_WRITE_MASK = 8'h33;

  // Core status fields.
  localparam int ST_POWERDOWN_BIT = 3;
  localparam int ST_TIMEOUT_BIT   = 4;
  localparam logic [7:0] ST_POR_VALUE = 8'h18;

  // Reset values.
  localparam logic [7:0] PCL_RESET_VALUE   = 8'h00;
  localparam logic [7:0] PCL_IRQ_VECTOR    = 8'h04;
  localparam logic [7:0] PORT_RESET_VALUE  = 8'h00;
  localparam logic [7:0] SSP_ADDR_RESET    = 8'h00;
  localparam logic [7:0] SSP_MASK_RESET    = 8'hff;
  localparam logic [3:0] SSP_MASK_MODE     = 4'h9;
  localparam logic [1:0] BOR_MODE_OFF      = 2'h0;
  localparam logic [1:0] BOR_MODE_SOFT     = 2'h1;

  // Timing: power-up timer and oscillator start-up counts.
  localparam int CLK_MHZ          = 125;
  localparam int PWRT_MS          = 64;
  localparam int LFOSC_HZ         = 31000;
  localparam int PWRT_LF_TICKS    = (PWRT_MS * LFOSC_HZ) / 1000;
  localparam int OST_OSC_PERIODS  = 1024;

  // Oscillator configuration.
  typedef enum logic [2:0] {
    RCS_OSC_RC, RCS_OSC_EXT, RCS_OSC_INTERNAL,
    RCS_OSC_CRYSTAL_STD, RCS_OSC_CRYSTAL_FAST, RCS_OSC_CRYSTAL_LOWPOWER
  } rcs_osc_e;

  // Reset and wake events, one-cycle pulses.
  typedef struct packed {
    logic poweron;
    logic brownout;
    logic master_clear;
    logic watchdog;
    logic irq_wake;
  } rcs_event_s;

  // Interrupt event bits.
  localparam int IRQ_W = 6;

endpackage : rcs_pkg

// >>> design/rcs_delay_counter.sv
// Down-counter used for the power-up timer and the oscillator start-up count.
// Assumes its tick enable is a single-cycle pulse in the clk_i domain.
`timescale 1ns/1ns
module rcs_delay_counter import rcs_pkg::*; #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  input  wire logic         tick_i,
  output logic              busy_o
);

  logic [W-1:0] remain;

  // Load wins over counting so a renewed reset restarts the delay.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      remain <= '0;
    end else if (ce_i) begin
      if (load_i) begin
        remain <= count_i;
      end else if (tick_i && remain != '0) begin
        remain <= remain - 1'b1;
      end
    end
  end

  assign busy_o = (remain != '0);

endmodule : rcs_delay_counter

// >>> design/rcs_tick_gen.sv
// Tick divider: produces one-cycle pulses at a slower rate from clk_i.
// Used to model the low-frequency internal and crystal oscillator periods.
`timescale 1ns/1ns
module rcs_tick_gen import rcs_pkg::*; #(
  parameter int DIV = 4032
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic ce_i,
  output logic      tick_o
);

  logic [15:0] cnt;

  // Counter wraps at DIV-1; the tick is registered so it is glitch free.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= (cnt == 16'(DIV - 1));
      cnt    <= (cnt == 16'(DIV - 1)) ? '0 : cnt + 16'h0001;
    end
  end

endmodule : rcs_tick_gen

// >>> design/rcs_reset_cause.sv
// Reset-cause recorder: status and power control flags, start-up delay,
// program counter low byte, port latches and serial address/mask registers.
// Assumes synchronous event pulses, an APB master on clk_i, and ce_i gating.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
module rcs_reset_cause import rcs_pkg::*; #(
  parameter int PWRT_LF_DIV  = (CLK_MHZ * 1000000) / LFOSC_HZ,
  parameter int OSC_DIV      = 4,
  parameter int PWRT_TICKS   = PWRT_LF_TICKS
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire rcs_event_s  event_i,
  input  wire logic        sleeping_i,
  input  wire logic        gie_i,
  input  wire rcs_osc_e    osc_mode_i,
  input  wire logic        timer1_osc_input_i,
  input  wire logic        powerup_timer_disable_i,
  input  wire logic [1:0]  brownout_enable_mode_i,
  output logic             core_reset_o,
  output logic             brownout_detect_en_o,
  output logic             irq_o
);

  // Register state.
  logic [7:0] core_status;
  logic [7:0] power_control_reg;
  logic [7:0] pc_low;
  logic [7:0] port_latch;
  logic [7:0] serial_addr;
  logic [7:0] serial_addr_mask_reg;
  logic [7:0] serial_port_control_reg;
  logic [1:0] wake_flags;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic             ulp_cfg;

  // Startup state.
  typedef enum logic [1:0] {RCS_RUN, RCS_PWRT, RCS_OST} rcs_seq_e;
  rcs_seq_e   seq;
  logic       lf_tick;
  logic       osc_tick;
  logic       pwrt_load;
  logic       ost_load;
  logic       pwrt_busy;
  logic       ost_busy;
  logic       crystal_mode;
  logic       ost_needed;

  // APB decode.
  logic apb_access;
  logic apb_wr;
  logic apb_rd;

  assign apb_access = psel_i && penable_i && ce_i;
  assign apb_wr     = apb_access && pwrite_i;
  assign apb_rd     = apb_access && !pwrite_i;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == ADDR_CORE_STATUS) || (a == ADDR_POWER_CONTROL) ||
                (a == ADDR_CONFIG) || (a == ADDR_IRQ_STATUS) ||
                (a == ADDR_IRQ_ENABLE) || (a == ADDR_IRQ_CLEAR) ||
                (a == ADDR_PC_LOW) || (a == ADDR_PORT_LATCH) ||
                (a == ADDR_SERIAL_ADDR) || (a == ADDR_SERIAL_CTRL) ||
                (a == ADDR_WAKE_FLAGS);
  endfunction : is_mapped

  function automatic logic wr_hit(input logic [11:0] a);
    wr_hit = apb_wr && (paddr_i == a);
  endfunction : wr_hit

  // Dividers for the 31 kHz oscillator and the crystal oscillator period.
  rcs_tick_gen #(.DIV(PWRT_LF_DIV)) u_lf_tick (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .tick_o   (lf_tick)
  );

  rcs_tick_gen #(.DIV(OSC_DIV)) u_osc_tick (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .tick_o   (osc_tick)
  );

  rcs_delay_counter #(.W(16)) u_pwrt (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .load_i   (pwrt_load),
    .count_i  (16'(PWRT_TICKS)),
    .tick_i   (lf_tick),
    .busy_o   (pwrt_busy)
  );

  rcs_delay_counter #(.W(16)) u_ost (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .load_i   (ost_load),
    .count_i  (16'(OST_OSC_PERIODS)),
    .tick_i   (osc_tick),
    .busy_o   (ost_busy)
  );

  // Crystal modes need the start-up count unless low-power crystal runs off
  // the timer1 input, where the oscillator is already stable.
  assign crystal_mode = (osc_mode_i == RCS_OSC_CRYSTAL_STD) ||
                        (osc_mode_i == RCS_OSC_CRYSTAL_FAST) ||
                        (osc_mode_i == RCS_OSC_CRYSTAL_LOWPOWER);
  assign ost_needed   = crystal_mode &&
                        !((osc_mode_i == RCS_OSC_CRYSTAL_LOWPOWER) && timer1_osc_input_i);

  // Timer loads: power-up timer only after power-on or brown-out reset.
  assign pwrt_load = (event_i.poweron || event_i.brownout) && !powerup_timer_disable_i;
  assign ost_load  = (seq == RCS_PWRT && !pwrt_busy && !pwrt_load && ost_needed) ||
                     ((event_i.poweron || event_i.brownout) && powerup_timer_disable_i &&
                      ost_needed) ||
                     (event_i.watchdog && sleeping_i && ost_needed) ||
                     (event_i.irq_wake && sleeping_i && ost_needed);

  // Start-up sequencer: power-up timer then oscillator start-up count.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seq <= RCS_PWRT;
    end else if (ce_i) begin
      case (seq)
        RCS_RUN: begin
          if (pwrt_load) begin
            seq <= RCS_PWRT;
          end else if (ost_load) begin
            seq <= RCS_OST;
          end
        end
        RCS_PWRT: begin
          if (pwrt_load) begin
            seq <= RCS_PWRT;
          end else if (!pwrt_busy) begin
            seq <= ost_needed ? RCS_OST : RCS_RUN;
          end
        end
        RCS_OST: begin
          if (pwrt_load) begin
            seq <= RCS_PWRT;
          end else if (!ost_busy && !ost_load) begin
            seq <= RCS_RUN;
          end
        end
        default: seq <= RCS_RUN;
      endcase
    end
  end

  // Internal reset held while a delay runs; flags were set at the event.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_reset_o <= 1'b1;
    end else if (ce_i) begin
      core_reset_o <= (seq != RCS_RUN) || pwrt_load || ost_load;
    end
  end

  // Power control flags. Hardware events win over software writes. The
  // asynchronous reset stands for power-on: poweron flag 0, brownout 0.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      power_control_reg <= 8'h00;
    end else if (ce_i) begin
      if (wr_hit(ADDR_POWER_CONTROL)) begin
        power_control_reg <= pwdata_i[7:0] & PC_WRITE_MASK;
      end
      if (event_i.poweron) begin
        power_control_reg[PC_POWERON_BIT] <= 1'b0;
      end
      if (event_i.brownout && brownout_enable_mode_i != BOR_MODE_OFF) begin
        power_control_reg[PC_BROWNOUT_BIT] <= 1'b0;
      end
    end
  end

  // Brown-out detection enable: soft control only in mode 01.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      brownout_detect_en_o <= 1'b0;
    end else if (ce_i) begin
      case (brownout_enable_mode_i)
        BOR_MODE_OFF:  brownout_detect_en_o <= 1'b0;
        BOR_MODE_SOFT: brownout_detect_en_o <= power_control_reg[PC_SOFT_BOR_BIT];
        2'h2:          brownout_detect_en_o <= !sleeping_i;
        default:       brownout_detect_en_o <= 1'b1;
      endcase
    end
  end

  // Core status register: timeout and powerdown flags per reset kind; the
  // bank and top bits clear on any reset, arithmetic flags hold except on power-on, which clears them.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_status <= ST_POR_VALUE;
    end else if (ce_i) begin
      if (wr_hit(ADDR_CORE_STATUS)) begin
        core_status <= {pwdata_i[7:5], core_status[4:3], pwdata_i[2:0]};
      end
      if (event_i.poweron) begin
        core_status <= ST_POR_VALUE;
      end else if (event_i.brownout) begin
        core_status <= {3'h0, 2'h3, core_status[2:0]};
      end else if (event_i.watchdog && sleeping_i) begin
        core_status[ST_TIMEOUT_BIT]   <= 1'b0;
        core_status[ST_POWERDOWN_BIT] <= 1'b0;
      end else if (event_i.watchdog) begin
        core_status <= {3'h0, 1'b0, core_status[3:0]};
      end else if (event_i.master_clear && sleeping_i) begin
        core_status <= {3'h0, 1'b1, 1'b0, core_status[2:0]};
      end else if (event_i.master_clear) begin
        core_status <= {3'h0, core_status[4:0]};
      end
    end
  end

  // Program counter low byte and wake flags.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc_low     <= PCL_RESET_VALUE;
      wake_flags <= 2'h0;
    end else if (ce_i) begin
      if (wr_hit(ADDR_PC_LOW)) begin
        pc_low <= pwdata_i[7:0];
      end
      if (wr_hit(ADDR_WAKE_FLAGS)) begin
        wake_flags <= wake_flags & ~pwdata_i[1:0];
      end
      if (event_i.poweron || event_i.brownout || event_i.master_clear ||
          (event_i.watchdog && !sleeping_i)) begin
        pc_low <= PCL_RESET_VALUE;
      end else if (sleeping_i && (event_i.watchdog || event_i.irq_wake)) begin
        pc_low <= (event_i.irq_wake && gie_i) ? PCL_IRQ_VECTOR : pc_low + 8'h01;
        wake_flags <= (wr_hit(ADDR_WAKE_FLAGS) ? wake_flags & ~pwdata_i[1:0] : wake_flags) |
                      {event_i.irq_wake, event_i.watchdog};
      end
    end
  end

  // Port latches: held on power-on, cleared by other resets, kept on wake.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_latch <= PORT_RESET_VALUE;
    end else if (ce_i) begin
      if (wr_hit(ADDR_PORT_LATCH)) begin
        port_latch <= pwdata_i[7:0];
      end
      if (event_i.brownout || event_i.master_clear ||
          (event_i.watchdog && !sleeping_i)) begin
        port_latch <= PORT_RESET_VALUE;
      end
    end
  end

  // Serial address and mask share one offset; mode selects the target.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      serial_addr             <= SSP_ADDR_RESET;
      serial_addr_mask_reg    <= SSP_MASK_RESET;
      serial_port_control_reg <= 8'h00;
      ulp_cfg                 <= 1'b0;
    end else if (ce_i) begin
      if (wr_hit(ADDR_SERIAL_CTRL)) begin
        serial_port_control_reg <= pwdata_i[7:0];
      end
      if (wr_hit(ADDR_SERIAL_ADDR)) begin
        if (serial_port_control_reg[3:0] == SSP_MASK_MODE) begin
          serial_addr_mask_reg <= pwdata_i[7:0];
        end else begin
          serial_addr <= pwdata_i[7:0];
        end
      end
      if (wr_hit(ADDR_CONFIG)) begin
        ulp_cfg <= pwdata_i[0];
      end
      if (event_i.poweron || event_i.brownout || event_i.master_clear ||
          (event_i.watchdog && !sleeping_i)) begin
        serial_addr             <= SSP_ADDR_RESET;
        serial_addr_mask_reg    <= SSP_MASK_RESET;
        serial_port_control_reg <= 8'h00;
      end
    end
  end

  // Interrupt status: sticky events; set wins over write-one-to-clear.
  logic [IRQ_W-1:0] irq_events;
  assign irq_events = {event_i.irq_wake, event_i.watchdog && sleeping_i,
                       event_i.watchdog && !sleeping_i, event_i.master_clear,
                       event_i.brownout, event_i.poweron};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status <= '0;
      irq_enable <= '0;
      irq_o      <= 1'b0;
    end else if (ce_i) begin
      if (wr_hit(ADDR_IRQ_ENABLE)) begin
        irq_enable <= pwdata_i[IRQ_W-1:0];
      end
      irq_status <= (irq_status &
                     ~(wr_hit(ADDR_IRQ_CLEAR) ? pwdata_i[IRQ_W-1:0] : '0)) | irq_events;
      irq_o      <= |(irq_status & irq_enable);
    end
  end

  // APB read data and answer: zero wait states, error on unmapped address.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o  <= '0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o  <= psel_i && !pready_o && !penable_i;
      pslverr_o <= psel_i && !pready_o && !penable_i && !is_mapped(paddr_i);
      prdata_o  <= '0;
      if (psel_i && !penable_i && !pwrite_i) begin
        case (paddr_i)
          ADDR_CORE_STATUS:   prdata_o <= {24'h0, core_status};
          ADDR_POWER_CONTROL: prdata_o <= {24'h0, power_control_reg & PC_WRITE_MASK};
          ADDR_CONFIG:        prdata_o <= {31'h0, ulp_cfg};
          ADDR_IRQ_STATUS:    prdata_o <= {{(32-IRQ_W){1'b0}}, irq_status};
          ADDR_IRQ_ENABLE:    prdata_o <= {{(32-IRQ_W){1'b0}}, irq_enable};
          ADDR_PC_LOW:        prdata_o <= {24'h0, pc_low};
          ADDR_PORT_LATCH:    prdata_o <= {24'h0, port_latch};
          ADDR_SERIAL_ADDR:   prdata_o <= {24'h0, (serial_port_control_reg[3:0] ==
                                           SSP_MASK_MODE) ? serial_addr_mask_reg
                                           : serial_addr};
          ADDR_SERIAL_CTRL:   prdata_o <= {24'h0, serial_port_control_reg};
          ADDR_WAKE_FLAGS:    prdata_o <= {30'h0, wake_flags};
          default:            prdata_o <= '0;
        endcase
      end
    end
  end

endmodule : rcs_reset_cause

// >>> tb/rcs_reset_cause_sva.sv
// Concurrent checks on the ports of the reset-cause recorder.
// Assumes one clock domain, clk_i, and the asynchronous active-low resetn_i.
`timescale 1ns/1ns
module rcs_reset_cause_sva import rcs_pkg::*; #(
  parameter int PWRT_LF_DIV = 4032,
  parameter int OSC_DIV     = 4,
  parameter int PWRT_TICKS  = 1984
) (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        ce_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire rcs_event_s  event_i,
  input wire logic        sleeping_i,
  input wire logic        gie_i,
  input wire rcs_osc_e    osc_mode_i,
  input wire logic        timer1_osc_input_i,
  input wire logic        powerup_timer_disable_i,
  input wire logic [1:0]  brownout_enable_mode_i,
  input wire logic        core_reset_o,
  input wire logic        brownout_detect_en_o,
  input wire logic        irq_o
);
  // All checks share the system clock and drop out while reset is held.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // The bus answers with no wait state, and only inside an access phase.
  ready_after_setup_a: assert property (psel_i && !penable_i && ce_i |=> pready_o)
    else $error("pready missing after setup");
  ready_in_access_a: assert property (pready_o |-> psel_i && penable_i && !$past(penable_i))
    else $error("pready outside access phase");
  err_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  unmapped_zero_a: assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  pc_reserved_a: assert property (pready_o && !pwrite_i && paddr_i == ADDR_POWER_CONTROL
    |-> prdata_o[7:6] == 2'h0 && prdata_o[3:2] == 2'h0)
    else $error("power control reserved bits set");
  // The power-up timer holds the core in reset from the cycle after the event.
  pwrt_hold_a: assert property (event_i.poweron && ce_i && !powerup_timer_disable_i
    |=> core_reset_o [*4])
    else $error("power-up hold too short");
  bor_off_a: assert property ((brownout_enable_mode_i == BOR_MODE_OFF) [*2]
    |-> !brownout_detect_en_o)
    else $error("brown-out detect on in mode 00");
  bor_on_a: assert property ((resetn_i && brownout_enable_mode_i == 2'h3) [*2]
    |-> brownout_detect_en_o)
    else $error("brown-out detect off in mode 11");
endmodule : rcs_reset_cause_sva

bind rcs_reset_cause rcs_reset_cause_sva #(.PWRT_LF_DIV(PWRT_LF_DIV), .OSC_DIV(OSC_DIV),
  .PWRT_TICKS(PWRT_TICKS)) u_sva (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .event_i(event_i), .sleeping_i(sleeping_i), .gie_i(gie_i), .osc_mode_i(osc_mode_i),
  .timer1_osc_input_i(timer1_osc_input_i), .powerup_timer_disable_i(powerup_timer_disable_i),
  .brownout_enable_mode_i(brownout_enable_mode_i), .core_reset_o(core_reset_o),
  .brownout_detect_en_o(brownout_detect_en_o), .irq_o(irq_o));

// >>> tb/tb.sv
// Self-checking bench for the reset-cause recorder, driven over APB.
// Assumes short timer parameters so start-up delays stay a few thousand cycles.
`timescale 1ns/1ns
module tb import rcs_pkg::*; ;
  `define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end

  typedef struct packed {
    rcs_event_s ev;
    logic slp;
    logic [1:0] st;
    logic [1:0] pc;
    logic [1:0] pcm;
  } rcs_row_s;
  typedef struct packed {
    rcs_osc_e osc;
    logic t1;
    logic dis;
    logic slp;
    int exp;
  } rcs_dly_s;

  logic clk_i, resetn_i, ce_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic sleeping_i, gie_i, timer1_osc_input_i, powerup_timer_disable_i;
  logic core_reset_o, brownout_detect_en_o, irq_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [1:0] brownout_enable_mode_i;
  rcs_event_s event_i;
  rcs_osc_e osc_mode_i;
  int err_count, total_checks, cnt;
  logic [31:0] rd;
  logic er;
  rcs_row_s rows [7];
  rcs_dly_s dly [7];

  rcs_reset_cause #(.PWRT_LF_DIV(2), .OSC_DIV(4), .PWRT_TICKS(4)) uut (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .event_i(event_i),
    .sleeping_i(sleeping_i), .gie_i(gie_i), .osc_mode_i(osc_mode_i),
    .timer1_osc_input_i(timer1_osc_input_i), .powerup_timer_disable_i(powerup_timer_disable_i),
    .brownout_enable_mode_i(brownout_enable_mode_i), .core_reset_o(core_reset_o),
    .brownout_detect_en_o(brownout_detect_en_o), .irq_o(irq_o));

  // Free-running 125 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rd = prdata_o;
    er = pslverr_o;
    if (n >= 50) err_count++;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e,
                       input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e & m, rd & m)
  endtask : rdchk

  // Pulse one event and wait, bounded, until the start-up hold is over.
  task automatic pulse(input rcs_event_s e, input logic slp);
    int n;
    @(posedge clk_i);
    event_i <= e;
    sleeping_i <= slp;
    @(posedge clk_i);
    event_i <= '0;
    repeat (3) @(posedge clk_i);
    n = 0;
    while (core_reset_o !== 1'b0 && n < 8000) begin
      @(posedge clk_i);
      n++;
    end
    sleeping_i <= 1'b0;
  endtask : pulse

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // Watchdog: the whole sequence needs well under 100,000 cycles.
  initial begin
    #800000;
    err_count++;
    give_verdict();
  end

  // Main sequence: reset values, table of reset causes, then awkward cases.
  initial begin
    {resetn_i, psel_i, penable_i, pwrite_i, sleeping_i, gie_i, timer1_osc_input_i} = '0;
    ce_i = 1'b1;
    paddr_i = '0;
    pwdata_i = '0;
    event_i = '0;
    osc_mode_i = RCS_OSC_RC;
    powerup_timer_disable_i = 1'b1;
    brownout_enable_mode_i = 2'h3;
    err_count = 0;
    total_checks = 0;
    // Rows: event {por,bor,master_clear_pin,wdt,irq}, asleep, {timeout,powerdown}, power_control bits 1:0, mask.
    rows = '{'{5'b00100, 0, 2'b11, 2'b11, 2'b11}, '{5'b00010, 0, 2'b01, 2'b11, 2'b11},
             '{5'b00100, 1, 2'b10, 2'b11, 2'b11}, '{5'b00010, 1, 2'b00, 2'b11, 2'b11},
             '{5'b00100, 0, 2'b00, 2'b11, 2'b11}, '{5'b01000, 0, 2'b11, 2'b10, 2'b11},
             '{5'b10000, 0, 2'b11, 2'b00, 2'b10}};
    // Delays in clocks: 4 timer ticks of 2 clocks, 1024 oscillator periods of 4 clocks.
    dly = '{'{RCS_OSC_CRYSTAL_STD, 0, 0, 0, 4104}, '{RCS_OSC_CRYSTAL_FAST, 0, 1, 0, 4096},
            '{RCS_OSC_RC, 0, 0, 0, 8}, '{RCS_OSC_INTERNAL, 0, 1, 0, 0},
            '{RCS_OSC_CRYSTAL_LOWPOWER, 1, 0, 0, 8}, '{RCS_OSC_CRYSTAL_STD, 0, 0, 1, 4096},
            '{RCS_OSC_EXT, 0, 0, 1, 0}};
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdchk("status por", ADDR_CORE_STATUS, 32'h18, 32'hf8);
    rdchk("power_control por", ADDR_POWER_CONTROL, 32'h0, 32'h02);
    apb(1'b1, ADDR_POWER_CONTROL, 32'hff);
    rdchk("power_control layout", ADDR_POWER_CONTROL, 32'h33, 32'hff);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ADDR_POWER_CONTROL, 32'h33);
      pulse(rows[i].ev, rows[i].slp);
      rdchk("status", ADDR_CORE_STATUS, {24'h0, 3'b000, rows[i].st, 3'b000}, 32'hf8);
      rdchk("power_control", ADDR_POWER_CONTROL, {30'h0, rows[i].pc}, {30'h0, rows[i].pcm});
    end
    // Unmapped address is refused and reads zero.
    apb(1'b0, 12'h7f0, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    // Mask register shares the address and shows only in mode 1001.
    apb(1'b1, ADDR_SERIAL_ADDR, 32'h5a);
    apb(1'b1, ADDR_SERIAL_CTRL, 32'h9);
    rdchk("mask reset", ADDR_SERIAL_ADDR, {24'h0, SSP_MASK_RESET}, 32'hff);
    apb(1'b1, ADDR_SERIAL_ADDR, 32'h3c);
    rdchk("mask", ADDR_SERIAL_ADDR, 32'h3c, 32'hff);
    apb(1'b1, ADDR_SERIAL_CTRL, 32'h0);
    rdchk("slave addr", ADDR_SERIAL_ADDR, 32'h5a, 32'hff);
    // Soft brown-out enable only counts in mode 01.
    brownout_enable_mode_i <= BOR_MODE_SOFT;
    apb(1'b1, ADDR_POWER_CONTROL, 32'h10);
    repeat (2) @(posedge clk_i);
    `CHK("bor soft on", 1'b1, brownout_detect_en_o)
    apb(1'b1, ADDR_POWER_CONTROL, 32'h00);
    repeat (2) @(posedge clk_i);
    `CHK("bor soft off", 1'b0, brownout_detect_en_o)
    brownout_enable_mode_i <= BOR_MODE_OFF;
    repeat (3) @(posedge clk_i);
    brownout_enable_mode_i <= 2'h3;
    // Wake-ups advance or vector the program counter and keep the port latch.
    apb(1'b1, ADDR_PORT_LATCH, 32'ha5);
    pulse(5'b00001, 1'b1);
    rdchk("pc wake", ADDR_PC_LOW, 32'h01, 32'hff);
    rdchk("wake flag", ADDR_WAKE_FLAGS, 32'h2, 32'h2);
    gie_i <= 1'b1;
    pulse(5'b00001, 1'b1);
    rdchk("pc vector", ADDR_PC_LOW, {24'h0, PCL_IRQ_VECTOR}, 32'hff);
    rdchk("port wake", ADDR_PORT_LATCH, 32'ha5, 32'hff);
    pulse(5'b00100, 1'b0);
    rdchk("pc master_clear_pin", ADDR_PC_LOW, 32'h0, 32'hff);
    rdchk("port master_clear_pin", ADDR_PORT_LATCH, 32'h0, 32'hff);
    // Interrupt: raise, mask, unmask, clear; status is read-only.
    apb(1'b1, ADDR_IRQ_CLEAR, 32'h3f);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h08);
    pulse(5'b00010, 1'b0);
    `CHK("irq raised", 1'b1, irq_o)
    apb(1'b1, ADDR_IRQ_STATUS, 32'h0);
    rdchk("irq status", ADDR_IRQ_STATUS, 32'h08, 32'h3f);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge clk_i);
    `CHK("irq masked", 1'b0, irq_o)
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h08);
    repeat (2) @(posedge clk_i);
    `CHK("irq unmasked", 1'b1, irq_o)
    apb(1'b1, ADDR_IRQ_CLEAR, 32'h08);
    repeat (2) @(posedge clk_i);
    `CHK("irq cleared", 1'b0, irq_o)
    // Start-up hold length per oscillator mode and timer setting.
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_i);
      osc_mode_i <= dly[i].osc;
      timer1_osc_input_i <= dly[i].t1;
      powerup_timer_disable_i <= dly[i].dis;
      sleeping_i <= dly[i].slp;
      event_i <= dly[i].slp ? 5'b00010 : 5'b10000;
      @(posedge clk_i);
      event_i <= '0;
      cnt = 0;
      for (int k = 0; k < 6000; k++) begin
        @(posedge clk_i);
        if (core_reset_o === 1'b1) cnt++;
        else if (k > 3) break;
      end
      `CHK("delay", 1'b1, (cnt + 2 >= dly[i].exp && cnt <= dly[i].exp + 6))
    end
    give_verdict();
  end
endmodule : tb
